// ---- ocs_top.sv ----
// Output data clock generation and multi-converter alignment, APB slave.
// Assumes pclk is the sample clock; reset pulse and reference clock are async pins.
// Function
// - Output words leave at the sampling rate, no rate change.
// - In-phase and quadrature output clocks always come from one source.
// - In demux mode the output clock divides the sample clock by four.
// - Delay trim also shifts the output clock phase.
// - A slave's reference phase clock sets its output clock to master's phase.
// - Alignment runs continuously and corrects any slip within one output cycle.
// - Reset pulse works only in extended control mode, off after reset.
// - Reset pulse may be asserted at any time, asynchronous to clock.
// - While pulsed, demux clock held high; non-demux clock keeps toggling.
// - After release, fixed delay, then next rising edge synchronises the clock.
// - Quadrature select high: synchronising edge four cycles after first edge.
// - Quadrature select low: synchronising edge five cycles after first edge.
// - Output clock restarts a constant delay after the synchronising edge.
// - First pulse after power-on may be undefined; later ones deterministic.
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`include "ocs_params.svh"

module ocs_top (
    input wire logic pclk,
    input wire logic presetn,
    input ocs_pkg::ocs_apb_req_t apb_req,
    output ocs_pkg::ocs_apb_rsp_t apb_rsp,
    input wire logic [`OCS_DATA_W-1:0] sample_in,
    input wire logic output_clock_reset_pulse,
    input wire logic reference_phase_clock,
    output ocs_pkg::ocs_clk_out_t clk_out,
    output ocs_pkg::ocs_data_out_t data_out
);
    import ocs_pkg::*;

    typedef struct packed {
        ocs_fsm_t fsm;
        logic [2:0] wcnt;
        logic [1:0] phase;
        logic first_seen;
        logic ref_prev;
        logic [4:0] ctrl;
        logic [1:0] trim;
        logic [1:0] phase_sel;
        logic [`OCS_DATA_W-1:0] hold_sample;
        ocs_data_out_t dout;
        ocs_clk_out_t cout;
        ocs_apb_rsp_t rsp;
    } ocs_state_t;

    ocs_state_t s;
    ocs_state_t next_s;
    logic [1:0] pin_sync;
    logic pulse_sync;
    logic ref_sync;
    logic pulse;
    logic ref_rise;
    logic demux;
    logic setup;
    logic access;
    logic [5:0] idx;
    logic [1:0] clk_phase;
    logic clk_bit;

    // Pins pass two flops before any use
    ocs_sync2 #(.W(2)) u_sync (
        .clk(pclk),
        .rst_n(presetn),
        .d({output_clock_reset_pulse, reference_phase_clock}),
        .q(pin_sync)
    );

    assign pulse_sync = pin_sync[1];
    assign ref_sync = pin_sync[0];
    // Pulse honoured only with extended control and reset function enabled
    assign pulse = pulse_sync & s.ctrl[`OCS_CTRL_ECM] & s.ctrl[`OCS_CTRL_RSTEN];
    assign ref_rise = ref_sync & ~s.ref_prev;
    assign demux = s.ctrl[`OCS_CTRL_DEMUX];
    assign setup = apb_req.psel & ~apb_req.penable;
    assign access = apb_req.psel & apb_req.penable & s.rsp.pready;
    assign idx = apb_req.paddr[7:2];

    always_comb begin
        next_s = s;
        clk_phase = 2'h0;
        clk_bit = 1'b0;
        next_s.ref_prev = ref_sync;

        // APB slave, one access cycle, registered answer
        next_s.rsp.pready = 1'b0;
        next_s.rsp.pslverr = 1'b0;
        if (setup) begin
            next_s.rsp.pready = 1'b1;
            next_s.rsp.prdata = 32'h0000_0000;
            if (apb_req.paddr[1:0] != 2'h0) begin
                next_s.rsp.pslverr = 1'b1;
            end else begin
                case (idx)
                    `OCS_IDX_CTRL: next_s.rsp.prdata[4:0] = s.ctrl;
                    `OCS_IDX_TRIM: next_s.rsp.prdata[1:0] = s.trim;
                    `OCS_IDX_STATUS: begin
                        next_s.rsp.prdata[`OCS_STAT_PHASE +: 2] = s.phase;
                        next_s.rsp.prdata[`OCS_STAT_FSM +: 2] = s.fsm;
                        next_s.rsp.prdata[`OCS_STAT_FIRST] = s.first_seen;
                        next_s.rsp.prdata[`OCS_STAT_PULSE] = pulse;
                    end
                    `OCS_IDX_PHASE: next_s.rsp.prdata[`OCS_PHASE_QSEL +: 2] = s.phase_sel;
                    default: next_s.rsp.pslverr = 1'b1;
                endcase
            end
        end
        // Write takes effect at the edge that completes the access
        if (access && apb_req.pwrite && !s.rsp.pslverr) begin
            case (idx)
                `OCS_IDX_CTRL: next_s.ctrl = apb_req.pwdata[4:0];
                `OCS_IDX_TRIM: next_s.trim = apb_req.pwdata[1:0];
                `OCS_IDX_PHASE: next_s.phase_sel = apb_req.pwdata[`OCS_PHASE_QSEL +: 2];
                default: next_s.ctrl = s.ctrl;
            endcase
        end

        // Free-running two-bit phase counter
        next_s.phase = s.phase + 2'h1;

        // Slave realigns on every reference edge unless a synchronising edge reloads the phase
        if (s.ctrl[`OCS_CTRL_ALIGN] && !s.ctrl[`OCS_CTRL_MASTER] && ref_rise) begin
            next_s.phase = `OCS_ALIGN_LOAD;
        end

        // Reset pulse sequence
        case (s.fsm)
            OCS_IDLE: begin
                if (pulse) begin
                    next_s.fsm = OCS_HOLD;
                end
            end
            OCS_HOLD: begin
                // First edge after release starts the fixed delay
                if (!pulse) begin
                    next_s.fsm = OCS_WAIT;
                    next_s.wcnt = s.phase_sel[0] ? `OCS_SYNC_DLY_90 - 3'h1 :
                                                   `OCS_SYNC_DLY_0 - 3'h1;
                end
            end
            OCS_WAIT: begin
                if (pulse) begin
                    next_s.fsm = OCS_HOLD;
                end else if (s.wcnt == 3'h0) begin
                    // Synchronising edge; first pulse after power-on not trusted
                    if (s.first_seen) begin
                        next_s.phase = `OCS_SYNC_LOAD;
                    end
                    next_s.first_seen = 1'b1;
                    next_s.fsm = OCS_RESTART;
                    next_s.wcnt = `OCS_CLK_OUT_DLY - 3'h1;
                end else begin
                    next_s.wcnt = s.wcnt - 3'h1;
                end
            end
            OCS_RESTART: begin
                // Constant output delay before the clock shows again
                if (pulse) begin
                    next_s.fsm = OCS_HOLD;
                end else if (s.wcnt == 3'h0) begin
                    next_s.fsm = OCS_IDLE;
                end else begin
                    next_s.wcnt = s.wcnt - 3'h1;
                end
            end
            default: next_s.fsm = OCS_IDLE;
        endcase

        // Trim shifts the produced clock edge
        clk_phase = next_s.phase + s.trim;
        clk_bit = (demux ? clk_phase[1] : clk_phase[0]) ^ s.phase_sel[1];
        // Demux clock parked high during the sequence, non-demux runs on
        if (demux && next_s.fsm != OCS_IDLE) begin
            clk_bit = 1'b1;
        end
        // Both output clocks from one bit
        next_s.cout.in_phase_output_clock = clk_bit;
        next_s.cout.quadrature_output_clock = clk_bit;
        next_s.cout.phase_clock_relay_out_a = s.ctrl[`OCS_CTRL_MASTER] ? clk_bit : ref_sync;
        next_s.cout.phase_clock_relay_out_b = s.ctrl[`OCS_CTRL_MASTER] ? clk_bit : ref_sync;

        // Data leaves at the sample rate, split over two buses in demux
        if (demux) begin
            if (s.phase[0]) begin
                next_s.dout.primary_output_bus = sample_in;
                next_s.dout.delayed_output_bus = s.hold_sample;
            end else begin
                next_s.hold_sample = sample_in;
            end
        end else begin
            next_s.dout.primary_output_bus = sample_in;
            next_s.dout.delayed_output_bus = '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.fsm <= OCS_IDLE;
            s.ctrl <= `OCS_CTRL_RST;
            s.trim <= `OCS_TRIM_RST;
            s.phase_sel <= `OCS_PHASE_RST;
        end else begin
            s <= next_s;
        end
    end

    assign apb_rsp = s.rsp;
    assign clk_out = s.cout;
    assign data_out = s.dout;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    same_phase_clk_a: assert property (
        clk_out.in_phase_output_clock == clk_out.quadrature_output_clock)
        else $error("in-phase and quadrature clocks differ");

    demux_park_a: assert property (
        (s.fsm != OCS_IDLE && demux && $past(demux)) |-> clk_out.in_phase_output_clock)
        else $error("demux clock not parked high during reset sequence");

    gate_off_a: assert property (
        (s.fsm == OCS_IDLE && !(s.ctrl[`OCS_CTRL_ECM] && s.ctrl[`OCS_CTRL_RSTEN]))
        |=> s.fsm == OCS_IDLE)
        else $error("reset pulse acted without extended control enable");

    sync_delay_90_a: assert property (
        (s.fsm == OCS_HOLD && !pulse && s.phase_sel[0]) ##1 (!pulse)[*4]
        |=> s.fsm == OCS_RESTART)
        else $error("quadrature mode synchronising edge not after four cycles");

    sync_delay_0_a: assert property (
        (s.fsm == OCS_HOLD && !pulse && !s.phase_sel[0]) ##1 ((!pulse) && s.fsm == OCS_WAIT)[*4]
        |=> s.fsm == OCS_WAIT ##1 s.fsm == OCS_RESTART)
        else $error("zero phase mode synchronising edge not after five cycles");

    out_delay_a: assert property (
        ($past(s.fsm) == OCS_WAIT && s.fsm == OCS_RESTART) ##0 (!pulse)[*3]
        |=> s.fsm == OCS_IDLE)
        else $error("output clock restart delay wrong");

    sync_reload_a: assert property (
        (s.fsm == OCS_WAIT && s.wcnt == 3'h0 && !pulse && s.first_seen)
        |=> s.phase == `OCS_SYNC_LOAD)
        else $error("phase counter not reloaded on synchronising edge");

    first_pulse_a: assert property (
        (s.fsm == OCS_WAIT && s.wcnt == 3'h0 && !pulse && !s.first_seen && !ref_rise)
        |=> s.phase == $past(s.phase) + 2'h1 && s.first_seen)
        else $error("first pulse after power-on reloaded the phase");

    align_fix_a: assert property (
        (s.ctrl[`OCS_CTRL_ALIGN] && !s.ctrl[`OCS_CTRL_MASTER] && ref_rise &&
         !(s.fsm == OCS_WAIT && s.wcnt == 3'h0))
        |=> s.phase == `OCS_ALIGN_LOAD)
        else $error("slave phase not taken from reference edge");

    data_rate_a: assert property (
        (!demux && $past(!demux)) |-> data_out.primary_output_bus == $past(sample_in))
        else $error("non-demux data not passed every cycle");

    pulse_reach_a: assert property (
        (s.ctrl[`OCS_CTRL_ECM] && s.ctrl[`OCS_CTRL_RSTEN] && output_clock_reset_pulse)[*3]
        ##1 (s.ctrl[`OCS_CTRL_ECM] && s.ctrl[`OCS_CTRL_RSTEN]) |=> s.fsm == OCS_HOLD)
        else $error("held reset pulse did not reach the sequence");

    sync_done_c: cover property (s.fsm == OCS_RESTART ##1 s.fsm == OCS_IDLE);
    align_hit_c: cover property (ref_rise && s.ctrl[`OCS_CTRL_ALIGN] && s.phase != `OCS_ALIGN_LOAD);
    apb_write_c: cover property (access && apb_req.pwrite && idx == `OCS_IDX_PHASE);
    demux_hold_c: cover property (demux && s.fsm == OCS_HOLD);
endmodule

// ---- ocs_params.svh ----
// Constants of the output clock synchronisation block.
// Assumes byte address = register index times four on a 32-bit APB bus.
`ifndef OCS_PARAMS_SVH
`define OCS_PARAMS_SVH

// Register indices, byte address is four times the index
`define OCS_IDX_CTRL 6'h00
`define OCS_IDX_TRIM 6'h01
`define OCS_IDX_STATUS 6'h02
`define OCS_IDX_PHASE 6'h0E

// Control register fields
`define OCS_CTRL_ECM 0
`define OCS_CTRL_RSTEN 1
`define OCS_CTRL_DEMUX 2
`define OCS_CTRL_ALIGN 3
`define OCS_CTRL_MASTER 4
`define OCS_CTRL_RST 5'h04

// Phase register fields, phase select pair at bits 3 and 4
`define OCS_PHASE_QSEL 3
`define OCS_PHASE_INV 4
`define OCS_PHASE_RST 2'h0
`define OCS_TRIM_RST 2'h0

// Status register fields
`define OCS_STAT_PHASE 0
`define OCS_STAT_FSM 2
`define OCS_STAT_FIRST 4
`define OCS_STAT_PULSE 5

// Timing in sample clock cycles
`define OCS_SYNC_DLY_90 3'h4
`define OCS_SYNC_DLY_0 3'h5
`define OCS_CLK_OUT_DLY 3'h3
`define OCS_SYNC_LOAD 2'h0
`define OCS_ALIGN_LOAD 2'h3

`define OCS_DATA_W 10

`endif

// ---- ocs_pkg.sv ----
// Types of the output clock synchronisation block.
// Assumes ocs_params.svh is on the include path.
`include "ocs_params.svh"

package ocs_pkg;

    typedef enum logic [1:0] {
        OCS_IDLE = 2'h0,
        OCS_HOLD = 2'h1,
        OCS_WAIT = 2'h3,
        OCS_RESTART = 2'h2
    } ocs_fsm_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } ocs_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } ocs_apb_rsp_t;

    typedef struct packed {
        logic in_phase_output_clock;
        logic quadrature_output_clock;
        logic phase_clock_relay_out_a;
        logic phase_clock_relay_out_b;
    } ocs_clk_out_t;

    typedef struct packed {
        logic [`OCS_DATA_W-1:0] primary_output_bus;
        logic [`OCS_DATA_W-1:0] delayed_output_bus;
    } ocs_data_out_t;

endpackage

// ---- ocs_sync2.sv ----
// Two flip-flop level synchroniser, one per bit.
// Assumes inputs are asynchronous to clk; only stage two is read outside.
`timescale 1ns/1ps

module ocs_sync2 #(
    parameter int W = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } ocs_sync_st_t;

    ocs_sync_st_t s;
    ocs_sync_st_t next_s;

    always_comb begin
        next_s = s;
        next_s.meta = d;
        next_s.stable = s.meta;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign q = s.stable;
endmodule

// ---- ocs_peer_model.sv ----
// Far-side model: a master relay clock and a capture register on one bus.
// Assumes the design drives clk_out and data_out from pclk.
`timescale 1ns/1ps
`include "ocs_params.svh"

module ocs_peer_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] ref_shift,
    input ocs_pkg::ocs_clk_out_t clk_out,
    input ocs_pkg::ocs_data_out_t data_out,
    output logic reference_phase_clock,
    output logic [`OCS_DATA_W-1:0] captured
);
    import ocs_pkg::*;
    logic [1:0] div;
    logic [1:0] ph;
    logic last_clk;

    // Quarter-rate relay clock, free running, phase set by ref_shift
    assign ph = div + ref_shift;
    assign reference_phase_clock = ~ph[1];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div <= 2'h0;
            last_clk <= 1'b0;
            captured <= '0;
        end else begin
            div <= div + 2'h1;
            last_clk <= clk_out.in_phase_output_clock;
            // Capture the primary bus only, on clock rise
            if (clk_out.in_phase_output_clock && !last_clk) begin
                captured <= data_out.primary_output_bus;
            end
        end
    end
endmodule

// ---- output_clock_sync_tb.sv ----
// Bench for the output clock block: registers, data, pulse and alignment.
// Assumes the design files and the peer model are compiled first.
`timescale 1ns/1ps
`include "ocs_params.svh"
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin num_errors++; \
$display("[ERR] %s expected %0h seen %0h", n, e, s); end end

module output_clock_sync_tb;
    import ocs_pkg::*;
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_TRIM = 8'h04;
    localparam logic [7:0] A_ST = 8'h08;
    localparam logic [7:0] A_PH = 8'h38;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic pulse_pin = 1'b0;
    logic [1:0] shift = 2'h0;
    logic [9:0] sample_in = 10'h000;
    logic [9:0] h0, h1, ppri, cap;
    ocs_apb_req_t req = '0;
    ocs_apb_rsp_t rsp;
    ocs_clk_out_t co;
    ocs_data_out_t dout;
    logic refc, pclkd, pref, err;
    logic [31:0] rd;
    int cyc = 0, rises = 0, last_rise = 0, ref_rise = 0, num_errors = 0, check_count = 0;
    int t0, t1, d0, r, rel, o90, o0;
    int gv[3] = '{4, 5, 6};
    bit nd_chk = 0, dm_chk = 0, held;

    always #12.5 pclk = ~pclk;

    ocs_top dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .sample_in(sample_in), .output_clock_reset_pulse(pulse_pin),
        .reference_phase_clock(refc), .clk_out(co), .data_out(dout));
    ocs_peer_model peer (.pclk(pclk), .presetn(presetn), .ref_shift(shift), .clk_out(co),
        .data_out(dout), .reference_phase_clock(refc), .captured(cap));

    // Monitor: clock edges, data relation, timeout
    always @(posedge pclk) begin
        sample_in <= 10'($urandom);
        cyc <= cyc + 1;
        if (presetn) begin
            `CHK("quad clock", co.in_phase_output_clock, co.quadrature_output_clock)
            if (co.in_phase_output_clock === 1'b1 && pclkd === 1'b0) begin
                rises <= rises + 1;
                last_rise <= cyc;
            end
            if (refc && !pref) ref_rise <= cyc;
            if (nd_chk) `CHK("primary bus", h0, dout.primary_output_bus)
            if (last_rise == cyc - 1) `CHK("captured bus", ppri, cap)
            if (dm_chk && dout.primary_output_bus !== ppri) begin
                `CHK("primary pair", h0, dout.primary_output_bus)
                `CHK("delayed pair", h1, dout.delayed_output_bus)
            end
        end
        pclkd <= co.in_phase_output_clock;
        pref <= refc;
        ppri <= dout.primary_output_bus;
        h1 <= h0;
        h0 <= sample_in;
        if (cyc > 20000) begin
            num_errors++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge pclk);
        req.penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        `CHK("apb answer", 1'b1, rsp.pready)
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic wait_rise(output int t);
        int r0, n;
        r0 = rises;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (rises == r0 && n < 60);
        t = last_rise;
    endtask

    task automatic hold_pulse(input int n, output int nr);
        int r0;
        @(posedge pclk);
        pulse_pin <= 1'b1;
        r0 = rises;
        held = 1;
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            if (i > 5 && co.in_phase_output_clock !== 1'b1) held = 0;
        end
        nr = rises - r0;
        pulse_pin <= 1'b0;
        rel = cyc;
    endtask

    task automatic sync_off(input logic q, output int off);
        apb(1'b1, A_PH, {28'h0, q, 3'h0});
        repeat (($urandom % 4) + 1) @(posedge pclk);
        hold_pulse(8, r);
        wait_rise(t0);
        off = t0 - rel;
    endtask

    initial begin
        void'($urandom(32'h3449));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, A_CTRL, 0);
        `CHK("ctrl reset", 32'h4, rd)
        apb(1'b0, A_TRIM, 0);
        `CHK("trim reset", 32'h0, rd)
        apb(1'b0, 8'h10, 0);
        `CHK("unmapped err", 1'b1, err)
        apb(1'b1, A_PH, 32'h8);
        apb(1'b0, A_PH, 0);
        `CHK("phase readback", 32'h8, rd)
        apb(1'b1, A_PH, 0);
        $display("test registers done");
        dm_chk <= 1'b1;
        wait_rise(t0);
        wait_rise(t1);
        dm_chk <= 1'b0;
        `CHK("demux period", 4, t1 - t0)
        r = $urandom_range(3, 1);
        apb(1'b1, A_TRIM, r);
        wait_rise(t1);
        wait_rise(t1);
        `CHK("trim shift", (4 - r) % 4, (t1 - t0) % 4)
        apb(1'b1, A_TRIM, 0);
        $display("test demux done");
        apb(1'b1, A_CTRL, 32'h3);
        repeat (4) @(posedge pclk);
        nd_chk <= 1'b1;
        wait_rise(t0);
        wait_rise(t1);
        nd_chk <= 1'b0;
        `CHK("plain period", 2, t1 - t0)
        hold_pulse(12, r);
        `CHK("plain clock runs", 1, r >= 5)
        repeat (16) @(posedge pclk);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, A_CTRL, gv[i]);
            hold_pulse(12, r);
            `CHK("gated clock runs", 1, r >= 2)
            apb(1'b0, A_ST, 0);
            `CHK("gated fsm idle", 2'h0, rd[3:2])
        end
        $display("test gating done");
        apb(1'b1, A_CTRL, 32'h7);
        sync_off(1'b1, o90);
        `CHK("held high", 1'b1, held)
        sync_off(1'b1, o90);
        sync_off(1'b1, r);
        `CHK("repeat offset", o90, r)
        sync_off(1'b0, o0);
        `CHK("select low offset", o90 + 1, o0)
        apb(1'b0, A_ST, 0);
        `CHK("first pulse seen", 1'b1, rd[4])
        $display("test sync done");
        apb(1'b1, A_CTRL, 32'hC);
        r = $urandom % 4;
        for (int k = 0; k < 4; k++) begin
            shift <= 2'(r + k);
            repeat (9) @(posedge pclk);
            wait_rise(t0);
            t1 = ((t0 - ref_rise) % 4 + 4) % 4;
            if (k == 0) d0 = t1;
            else `CHK("aligned phase", d0, t1)
        end
        $display("test alignment done");
        report_and_stop();
    end
endmodule
